//--- hdl/apcr_bit_divider.v
// Bit-clock divider: one-cycle output edges from a source enable.
// Assumes the source clock arrives as a one-cycle enable on mclk.
`timescale 1ns/100ps

module apcr_bit_divider (
    input  wire       mclk,       // System clock
    input  wire       srst,       // Synchronous reset, high
    input  wire       run,        // Divider powered and allowed
    input  wire       srcTick,    // Source clock enable pulse
    input  wire [6:0] divValue,   // Ratio, zero means 128
    output reg        bitClk      // Divided clock level
);

    reg [7:0] count;              // Source ticks in this period
    wire [7:0] ratio;             // Effective ratio
    wire [7:0] halfPoint;         // Tick where level falls

    // Zero codes the largest ratio
    assign ratio = (divValue == 7'h00) ? 8'h80 : {1'b0, divValue};
    assign halfPoint = {1'b0, ratio[7:1]};

    // ------------------------------------------------------------
    // Counter; ratio 1 simply toggles per tick
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst || !run) begin
            count  <= 8'h00;
            bitClk <= 1'b0;                          // [RQ4]
        end else if (srcTick) begin
            if (ratio == 8'h01) begin
                bitClk <= ~bitClk;                   // [RQ22]
            // At or past the end: a ratio lowered mid-period must not
            // leave the count to run the long way round the wrap
            end else if (count >= ratio - 8'h01) begin
                count  <= 8'h00;
                bitClk <= 1'b1;                      // [RQ5]
            end else begin
                count <= count + 8'h01;
                if (count + 8'h01 == halfPoint) begin
                    bitClk <= 1'b0;                  // [RQ22]
                end
            end
        end
    end

endmodule

//--- hdl/apcr_defines.vh
// Constants for the audio port clock routing block.
// Assumes an 8-bit register port with 8-bit word addresses.
`ifndef APCR_DEFINES_VH
`define APCR_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define APCR_ADDR_CLK_OPTIONS   8'h1D
`define APCR_ADDR_BIT_DIVIDER   8'h1E
`define APCR_ADDR_SEC_SOURCE    8'h1F
`define APCR_ADDR_INPUT_SELECT  8'h20
`define APCR_ADDR_OUTPUT_SELECT 8'h21
`define APCR_ADDR_BUS_OPTIONS   8'h22
`define APCR_ADDR_RSVD_A        8'h23
`define APCR_ADDR_RSVD_B        8'h24
`define APCR_ADDR_POWER_FLAGS   8'h25

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define APCR_RST_CLK_OPTIONS    8'h00
`define APCR_RST_BIT_DIVIDER    8'h01
`define APCR_RST_SEC_SOURCE     8'h00
`define APCR_RST_INPUT_SELECT   8'h00
`define APCR_RST_OUTPUT_SELECT  8'h00
`define APCR_RST_BUS_OPTIONS    8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define APCR_BIT_INVERT         3
`define APCR_BIT_KEEP_ALIVE     2
`define APCR_BIT_DIV_POWER      7
`define APCR_BIT_IN_BCLK_SEL    3
`define APCR_BIT_IN_FCLK_SEL    2
`define APCR_BIT_IN_DATA_SEL    0
`define APCR_BIT_OUT_PBCLK      7
`define APCR_BIT_OUT_SBCLK      6
`define APCR_BIT_GENCALL        5

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define APCR_SRC_PROC_CLK       2'h0
`define APCR_SRC_MOD_CLK        2'h1
`define APCR_SEC3_FROM_PIN      3'h0
`define APCR_SEC2_FROM_PIN      2'h0
`define APCR_PFCLK_GEN          2'h0
`define APCR_PFCLK_SEC          2'h2
`define APCR_SFCLK_PRI          2'h0
`define APCR_SFCLK_GEN          2'h1
`define APCR_DIV_WIDTH          7

`endif

//--- hdl/apcr_top.v
// Audio port clock routing: registers, divider and pin muxes.
// Assumes register port strobes and all pins are synchronous to mclk.
// What this block does
// [RQ1] Polarity bit inverts both bit-clock paths
// [RQ2] Keep-alive keeps clocks running at power-down
// [RQ3] Divider source: processing or modulator clock
// [RQ4] Divider runs only when power bit set
// [RQ5] Divide value 1..127, zero means 128
// [RQ6] Secondary bit clock taken from general pin
// [RQ7] Secondary frame clock taken from general pin
// [RQ8] Secondary data taken from general pin
// [RQ9] Select primary or secondary bit clock inward
// [RQ10] Select primary or secondary frame clock inward
// [RQ11] Select primary or secondary data inward
// [RQ12] Primary bit pin: generated or secondary
// [RQ13] Secondary bit pin: primary or generated
// [RQ14] Primary frame pin: sample clock or secondary
// [RQ15] Secondary frame pin: primary or sample clock
// [RQ16] General-call accepted only when bit set
// [RQ17] Host writes zeros to reserved bits
// [RQ18] Status shows converter channel power
// [RQ19] Status shows headphone driver power
// [RQ20] Status shows speaker channel power
// [RQ21] Direction bit makes bit-clock pin output
// [RQ22] Generated clock is source over ratio; ratio 1 toggles per tick, giving source over 2
`timescale 1ns/100ps
`include "apcr_defines.vh"

module apcr_top (
    input  wire       mclk,          // System clock, 100 MHz
    input  wire       srst,          // Synchronous reset, high
    // Register port
    input  wire [7:0] regAddr,       // Register offset
    input  wire [7:0] regWrData,     // Write data
    input  wire       regWrEn,       // Write strobe
    input  wire       regRdEn,       // Read strobe
    output reg  [7:0] regRdData,     // Read data
    // Device context
    input  wire       converterPowered, // Converter power state
    input  wire       bitClkIsOutput,   // Direction from port ctrl
    input  wire       frameClkIsOutput, // Frame direction
    input  wire       procClkTick,      // Processing clock enable
    input  wire       modClkTick,       // Modulator clock enable
    input  wire       sampleRateClk,    // Generated sample clock
    input  wire       leftConvPower,    // Left converter power
    input  wire       rightConvPower,   // Right converter power
    input  wire       leftHeadphonePower,  // Left headphone driver
    input  wire       rightHeadphonePower, // Right headphone driver
    input  wire       leftSpeakerPower,    // Left speaker channel
    input  wire       rightSpeakerPower,   // Right speaker channel
    input  wire       generalCallSeen,  // Bus saw general-call address
    output reg        generalCallAck,   // Respond to general call
    // Primary pins
    input  wire       priBitClkIn,   // Primary bit clock pin in
    output reg        priBitClkOut,  // Primary bit clock pin out
    output reg        priBitClkOe_n, // Low while driving
    input  wire       priFrameClkIn, // Primary frame pin in
    output reg        priFrameClkOut,// Primary frame pin out
    input  wire       priDataIn,     // Primary serial data
    // Secondary pins
    input  wire       gpioOneIn,     // General-purpose pin one
    input  wire       altBitClkIn,   // Secondary bit clock, other pin
    input  wire       altFrameClkIn, // Secondary frame, other pin
    input  wire       altDataIn,     // Secondary data, other pin
    output reg        secBitClkOut,  // Secondary bit clock out
    output reg        secFrameClkOut,// Secondary frame clock out
    // Toward serial interface and clock generator
    output reg        serialBitClk,  // Selected bit clock
    output reg        serialFrameClk,// Selected frame clock
    output reg        serialData     // Selected data input
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] clkOptions;     // Polarity, keep-alive, source
    reg [7:0] bitDivider;     // Power and divide value
    reg [7:0] secSource;      // Secondary pin sources
    reg [7:0] inputSelect;    // Inward selects
    reg [7:0] outputSelect;   // Outward selects
    reg [7:0] busOptions;     // General-call acceptance
    reg [7:0] rsvdA;          // Reserved slot, stored
    reg [7:0] rsvdB;          // Reserved slot, stored

    // Register writes; host keeps reserved bits at zero [RQ17]
    always @(posedge mclk) begin
        if (srst) begin
            clkOptions   <= `APCR_RST_CLK_OPTIONS;
            bitDivider   <= `APCR_RST_BIT_DIVIDER;
            secSource    <= `APCR_RST_SEC_SOURCE;
            inputSelect  <= `APCR_RST_INPUT_SELECT;
            outputSelect <= `APCR_RST_OUTPUT_SELECT;
            busOptions   <= `APCR_RST_BUS_OPTIONS;
            rsvdA        <= 8'h00;
            rsvdB        <= 8'h00;
        end else if (regWrEn) begin
            case (regAddr)
                `APCR_ADDR_CLK_OPTIONS:   clkOptions   <= regWrData;
                `APCR_ADDR_BIT_DIVIDER:   bitDivider   <= regWrData;
                `APCR_ADDR_SEC_SOURCE:    secSource    <= regWrData;
                `APCR_ADDR_INPUT_SELECT:  inputSelect  <= regWrData;
                `APCR_ADDR_OUTPUT_SELECT: outputSelect <= regWrData;
                `APCR_ADDR_BUS_OPTIONS:   busOptions   <= regWrData;
                `APCR_ADDR_RSVD_A:        rsvdA        <= regWrData;
                `APCR_ADDR_RSVD_B:        rsvdB        <= regWrData;
                default: ;                // Other offsets not here
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port, registered one cycle after the strobe
    // ------------------------------------------------------------
    wire [7:0] powerFlags;    // Live power status

    // Reserved status bits read zero
    assign powerFlags = {leftConvPower, 1'b0, leftHeadphonePower,
                         leftSpeakerPower, rightConvPower, 1'b0,
                         rightHeadphonePower, rightSpeakerPower};
                                                   // [RQ18] [RQ19] [RQ20]

    always @(posedge mclk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `APCR_ADDR_CLK_OPTIONS:   regRdData <= clkOptions;
                `APCR_ADDR_BIT_DIVIDER:   regRdData <= bitDivider;
                `APCR_ADDR_SEC_SOURCE:    regRdData <= secSource;
                `APCR_ADDR_INPUT_SELECT:  regRdData <= inputSelect;
                `APCR_ADDR_OUTPUT_SELECT: regRdData <= outputSelect;
                `APCR_ADDR_BUS_OPTIONS:   regRdData <= busOptions;
                `APCR_ADDR_RSVD_A:        regRdData <= rsvdA;
                `APCR_ADDR_RSVD_B:        regRdData <= rsvdB;
                `APCR_ADDR_POWER_FLAGS:   regRdData <= powerFlags;
                default:                  regRdData <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bit-clock divider
    // ------------------------------------------------------------
    wire       invert;        // Bit clock polarity
    wire       keepAlive;     // Clocks live at power-down
    wire [1:0] divSource;     // Divider source code
    wire       divPowered;    // Divider power bit
    wire       clocksAllowed; // Power or keep-alive permits
    reg        srcTick;       // Chosen source enable
    wire       genBitClk;     // Generated bit clock level

    assign invert     = clkOptions[`APCR_BIT_INVERT];
    assign keepAlive  = clkOptions[`APCR_BIT_KEEP_ALIVE];
    assign divSource  = clkOptions[1:0];
    assign divPowered = bitDivider[`APCR_BIT_DIV_POWER];
    assign clocksAllowed = converterPowered | keepAlive;   // [RQ2]

    // Source select; reserved codes feed no ticks
    always @* begin
        case (divSource)
            `APCR_SRC_PROC_CLK: srcTick = procClkTick;     // [RQ3]
            `APCR_SRC_MOD_CLK:  srcTick = modClkTick;      // [RQ3]
            default:            srcTick = 1'b0;
        endcase
    end

    apcr_bit_divider u_divider (
        .mclk     (mclk),
        .srst     (srst),
        .run      (divPowered & clocksAllowed),          // [RQ4]
        .srcTick  (srcTick),
        .divValue (bitDivider[`APCR_DIV_WIDTH-1:0]),
        .bitClk   (genBitClk)
    );

    // ------------------------------------------------------------
    // Secondary pin sources
    // ------------------------------------------------------------
    wire secBitClk;           // Secondary bit clock
    wire secFrameClk;         // Secondary frame clock
    wire secData;             // Secondary data

    assign secBitClk = (secSource[7:5] == `APCR_SEC3_FROM_PIN) ?
                       gpioOneIn : altBitClkIn;            // [RQ6]
    assign secFrameClk = (secSource[4:2] == `APCR_SEC3_FROM_PIN) ?
                       gpioOneIn : altFrameClkIn;          // [RQ7]
    assign secData = (secSource[1:0] == `APCR_SEC2_FROM_PIN) ?
                       gpioOneIn : altDataIn;              // [RQ8]

    // ------------------------------------------------------------
    // Registered routing of inward and outward clocks
    // ------------------------------------------------------------
    reg nextPriBit;           // Primary bit pin level
    reg nextSecBit;           // Secondary bit pin level
    reg nextPriFrame;         // Primary frame pin level
    reg nextSecFrame;         // Secondary frame pin level
    reg nextInBit;            // Inward bit clock

    // Muxes; reserved codes drive low
    always @* begin
        nextPriBit = outputSelect[`APCR_BIT_OUT_PBCLK] ?
                     secBitClk : genBitClk;                // [RQ12]
        nextSecBit = outputSelect[`APCR_BIT_OUT_SBCLK] ?
                     genBitClk : priBitClkIn;              // [RQ13]
        case (outputSelect[5:4])
            `APCR_PFCLK_GEN: nextPriFrame = sampleRateClk; // [RQ14]
            `APCR_PFCLK_SEC: nextPriFrame = secFrameClk;   // [RQ14]
            default:         nextPriFrame = 1'b0;
        endcase
        case (outputSelect[3:2])
            `APCR_SFCLK_PRI: nextSecFrame = priFrameClkIn; // [RQ15]
            `APCR_SFCLK_GEN: nextSecFrame = sampleRateClk; // [RQ15]
            default:         nextSecFrame = 1'b0;
        endcase
        if (!clocksAllowed) begin
            nextPriFrame = 1'b0;                           // [RQ2]
        end
        nextInBit = inputSelect[`APCR_BIT_IN_BCLK_SEL] ?
                    secBitClk : priBitClkIn;               // [RQ9]
    end

    // Pins and inward signals from flip-flops; polarity applied
    // once here so both bit-clock paths see it alike
    always @(posedge mclk) begin
        if (srst) begin
            priBitClkOut   <= 1'b0;
            priBitClkOe_n  <= 1'b1;
            secBitClkOut   <= 1'b0;
            priFrameClkOut <= 1'b0;
            secFrameClkOut <= 1'b0;
            serialBitClk   <= 1'b0;
            serialFrameClk <= 1'b0;
            serialData     <= 1'b0;
            generalCallAck <= 1'b0;
        end else begin
            priBitClkOut   <= nextPriBit ^ invert;          // [RQ1]
            priBitClkOe_n  <= ~bitClkIsOutput;              // [RQ21]
            secBitClkOut   <= nextSecBit ^ invert;          // [RQ1]
            priFrameClkOut <= frameClkIsOutput & nextPriFrame;
            secFrameClkOut <= nextSecFrame;
            serialBitClk   <= nextInBit ^ invert;           // [RQ1]
            serialFrameClk <= inputSelect[`APCR_BIT_IN_FCLK_SEL] ?
                              secFrameClk : priFrameClkIn;  // [RQ10]
            serialData     <= inputSelect[`APCR_BIT_IN_DATA_SEL] ?
                              secData : priDataIn;          // [RQ11]
            generalCallAck <= generalCallSeen &
                              busOptions[`APCR_BIT_GENCALL]; // [RQ16]
        end
    end

endmodule

//--- testbench/apcr_assertions.sv
// Port-level properties of the audio port clock routing top.
// Assumes a bind onto apcr_top; config writes are shadowed here.
`timescale 1ns/100ps
`include "apcr_defines.vh"
module apcr_assertions (
    input wire       mclk,
    input wire       srst,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrEn,
    input wire       regRdEn,
    input wire [7:0] regRdData,
    input wire       bitClkIsOutput,
    input wire       sampleRateClk,
    input wire       generalCallSeen,
    input wire       generalCallAck,
    input wire       priBitClkIn,
    input wire       priBitClkOe_n,
    input wire       priFrameClkIn,
    input wire       priDataIn,
    input wire       gpioOneIn,
    input wire       altBitClkIn,
    input wire       altFrameClkIn,
    input wire       altDataIn,
    input wire       secBitClkOut,
    input wire       secFrameClkOut,
    input wire       serialBitClk,
    input wire       serialFrameClk,
    input wire       serialData
);
// ----
// Shadow registers
// ----
reg [7:0] opt, src, sel, outs, bus;
reg       live;    // Low on the first edge after reset: $past unsafe
always @(posedge mclk) begin
    live <= !srst;
    if (srst) begin
        opt <= `APCR_RST_CLK_OPTIONS;
        src <= `APCR_RST_SEC_SOURCE;
        sel <= `APCR_RST_INPUT_SELECT;
        outs <= `APCR_RST_OUTPUT_SELECT;
        bus <= `APCR_RST_BUS_OPTIONS;
    end else if (regWrEn) begin
        case (regAddr)
            `APCR_ADDR_CLK_OPTIONS:   opt <= regWrData;
            `APCR_ADDR_SEC_SOURCE:    src <= regWrData;
            `APCR_ADDR_INPUT_SELECT:  sel <= regWrData;
            `APCR_ADDR_OUTPUT_SELECT: outs <= regWrData;
            `APCR_ADDR_BUS_OPTIONS:   bus <= regWrData;
            default: ;
        endcase
    end
end
// Secondary lines; every code but the pin code takes the other pin
wire sb = (src[7:5] == 3'h0) ? gpioOneIn : altBitClkIn;
wire sf = (src[4:2] == 3'h0) ? gpioOneIn : altFrameClkIn;
wire sd = (src[1:0] == 2'h0) ? gpioOneIn : altDataIn;
wire eBit = (sel[3] ? sb : priBitClkIn) ^ opt[3];
wire eFrame = sel[2] ? sf : priFrameClkIn;
wire eData = sel[0] ? sd : priDataIn;
wire eSecBit = priBitClkIn ^ opt[3];
wire priSel = ~outs[6];
wire eSecFr = (outs[3:2] == 2'h0) ? priFrameClkIn :
              ((outs[3:2] == 2'h1) ? sampleRateClk : 1'b0);
wire gcOk = generalCallSeen & bus[5];
// ----
// Properties
// ----
default clocking cb @(posedge mclk); endclocking
default disable iff (srst);
sequence sReadSel;
    regRdEn && regAddr == `APCR_ADDR_INPUT_SELECT;
endsequence
sequence sDirRise;
    $rose(bitClkIsOutput);
endsequence
AST_BCLK_IN: assert property (live |-> serialBitClk == $past(eBit))
    else $error("inward bit clock wrong");
AST_FCLK_IN: assert property (live |-> serialFrameClk == $past(eFrame))
    else $error("inward frame clock wrong");
AST_DATA_IN: assert property (live |-> serialData == $past(eData))
    else $error("inward data wrong");
AST_SEC_BCLK: assert property (live && $past(priSel) |-> secBitClkOut == $past(eSecBit))
    else $error("secondary bit clock out wrong");
AST_SEC_FCLK: assert property (live |-> secFrameClkOut == $past(eSecFr))
    else $error("secondary frame clock out wrong");
AST_GCALL_ON: assert property (gcOk |=> generalCallAck)
    else $error("general call not answered");
AST_GCALL_OFF: assert property (!gcOk |=> !generalCallAck)
    else $error("general call answered while off");
AST_DIR_OUT: assert property (sDirRise |=> !priBitClkOe_n)
    else $error("bit clock pin not driven");
AST_DIR_IN: assert property ($fell(bitClkIsOutput) |=> priBitClkOe_n)
    else $error("bit clock pin not released");
AST_SEL_READ: assert property (sReadSel |=> regRdData == $past(sel))
    else $error("input select readback wrong");
endmodule
bind apcr_top apcr_assertions u_apcr_assertions (.*);

//--- testbench/apcr_bench.sv
// Bench: self-checking run of the audio port clock routing top.
// Assumes the host model and the checker bind are compiled first.
`timescale 1ns/100ps
`include "apcr_defines.vh"
module apcr_bench;
reg        mclk, srst, regWrEn, regRdEn, converterPowered;
reg  [7:0] regAddr, regWrData;
reg        bitClkIsOutput, procClkTick, modClkTick, generalCallSeen;
reg  [5:0] pwr;             // Power levels, left converter first
wire [7:0] regRdData;
wire       priBitClkOut, priBitClkOe_n, priFrameClkOut, secBitClkOut;
wire       secFrameClkOut, serialBitClk, serialFrameClk, serialData;
wire       generalCallAck, hBit, priFrameClkIn, priDataIn, gpioOneIn;
wire       altBitClkIn, altFrameClkIn, altDataIn;
integer    bad_count, tests_run, cyc;
wire frameClkIsOutput = 1'b1;
wire sampleRateClk = cyc[2];            // Slow so it differs from pins
wire leftConvPower = pwr[5];
wire leftHeadphonePower = pwr[4];
wire leftSpeakerPower = pwr[3];
wire rightConvPower = pwr[2];
wire rightHeadphonePower = pwr[1];
wire rightSpeakerPower = pwr[0];
// Shared bit clock wire: whoever is enabled sets the level
wire priBitClkIn = priBitClkOe_n ? hBit : priBitClkOut;
apcr_top u_apcr_top (.*);
apcr_host_model u_apcr_host_model (.mclk(mclk), .srst(srst),
    .hostOwns(priBitClkOe_n), .bitClk(hBit), .frameClk(priFrameClkIn),
    .data(priDataIn), .gpioLine(gpioOneIn), .altBit(altBitClkIn),
    .altFrame(altFrameClkIn), .altData(altDataIn));
initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end
// Cycle count, modulator ticks and hang guard
always @(posedge mclk) begin
    cyc <= cyc + 1;
    modClkTick <= ~modClkTick;
    if (cyc == 10000) begin
        bad_count = bad_count + 1;
        tally_and_finish;
    end
end
task tally_and_finish;
    begin
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
endtask
task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
        tests_run = tests_run + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("BAD %0s expected %h seen %h", nm, e, g);
        end
    end
endtask
task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
    end
endtask
task rd(input [7:0] a, input [7:0] e);
    begin
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        @(negedge mclk);
        chk("regRdData", e, regRdData);
    end
endtask
task settle;
    begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    end
endtask
task test_regs;
    integer a;
    begin
        for (a = 8'h1D; a <= 8'h24; a = a + 1)
            rd(a[7:0], (a == 8'h1E) ? `APCR_RST_BIT_DIVIDER : 8'h00);
        rd(8'h40, 8'h00);
        for (a = 8'h1D; a <= 8'h21; a = a + 1) begin
            wr(a[7:0], a[7:0] ^ 8'hA5);
            rd(a[7:0], a[7:0] ^ 8'hA5);
        end
        wr(8'h22, 8'h20);
        rd(8'h22, 8'h20);
        wr(8'h25, 8'hFF);
        rd(8'h25, 8'h00);
    end
endtask
task test_status;
    integer i;
    reg [5:0] p;
    begin
        for (i = 0; i < 7; i = i + 1) begin
            p = (i == 6) ? 6'h3F : (6'h01 << i);
            @(posedge mclk);
            pwr <= p;
            rd(8'h25, {p[5], 1'b0, p[4:2], 1'b0, p[1:0]});
        end
    end
endtask
task test_control;
    begin
        wr(8'h22, 8'h00);
        generalCallSeen <= 1'b1;
        settle;
        chk("generalCallAck", 8'h00, generalCallAck);
        wr(8'h22, 8'h20);
        settle;
        chk("generalCallAck", 8'h01, generalCallAck);
        @(posedge mclk);
        bitClkIsOutput <= 1'b1;
        settle;
        chk("priBitClkOe_n", 8'h00, priBitClkOe_n);
        @(posedge mclk);
        bitClkIsOutput <= 1'b0;
        settle;
        chk("priBitClkOe_n", 8'h01, priBitClkOe_n);
    end
endtask
task route(input [7:0] src, input [7:0] sel, input [7:0] outs,
           input [7:0] opt);
    integer i;
    reg pb, pf, pd, g, ab, af, ad, sr, sb, sf, sd, iv;
    begin
        wr(8'h1F, src);
        wr(8'h20, sel);
        wr(8'h21, outs);
        wr(8'h1D, opt);
        iv = opt[3];
        for (i = 0; i < 12; i = i + 1) begin
            @(negedge mclk);
            {pb, pf, pd, g} = {priBitClkIn, priFrameClkIn, priDataIn, gpioOneIn};
            {ab, af, ad, sr} = {altBitClkIn, altFrameClkIn, altDataIn, sampleRateClk};
            // Any code but the pin code takes the other pin
            sb = (src[7:5] == 3'h0) ? g : ab;
            sf = (src[4:2] == 3'h0) ? g : af;
            sd = (src[1:0] == 2'h0) ? g : ad;
            @(negedge mclk);
            chk("serialBitClk", (sel[3] ? sb : pb) ^ iv, serialBitClk);
            chk("serialFrameClk", sel[2] ? sf : pf, serialFrameClk);
            chk("serialData", sel[0] ? sd : pd, serialData);
            if (!outs[6])
                chk("secBitClkOut", pb ^ iv, secBitClkOut);
            if (outs[7])
                chk("priBitClkOut", sb ^ iv, priBitClkOut);
            chk("secFrameClkOut", (outs[3:2] == 2'h0) ? pf : ((outs[3:2] == 2'h1) ? sr : 1'b0), secFrameClkOut);
            chk("priFrameClkOut", (outs[5:4] == 2'h0) ? sr : ((outs[5:4] == 2'h2) ? sf : 1'b0), priFrameClkOut);
        end
    end
endtask
task dv(input [7:0] opt, input [7:0] div, input pw, input [7:0] e);
    integer i, f, s;
    reg last;
    begin
        wr(8'h1D, opt);
        wr(8'h1E, div);
        converterPowered <= pw;
        repeat (4) @(negedge mclk);
        f = -1;
        s = -1;
        last = priBitClkOut;
        // Distance between the first two rising edges seen
        for (i = 0; i < 300; i = i + 1) begin
            @(negedge mclk);
            if (priBitClkOut === 1'b1 && last === 1'b0 && f >= 0 && s < 0)
                s = i;
            if (priBitClkOut === 1'b1 && last === 1'b0 && f < 0)
                f = i;
            last = priBitClkOut;
        end
        chk("bitPeriod", e, (s < 0) ? 8'h00 : 8'(s - f));
    end
endtask
initial begin
    {srst, regWrEn, regRdEn, bitClkIsOutput, generalCallSeen} = 5'h10;
    {converterPowered, procClkTick, modClkTick} = 3'h6;
    {regAddr, regWrData, pwr} = 22'h000000;
    {bad_count, tests_run, cyc} = 96'h0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    test_regs;
    test_status;
    test_control;
    route(8'h00, 8'h00, 8'h00, 8'h00);
    route(8'h00, 8'h0D, 8'hC0, 8'h08);
    route(8'h25, 8'h0D, 8'h24, 8'h08);
    route(8'h4A, 8'h0D, 8'h9C, 8'h00);
    wr(8'h21, 8'h00);
    dv(8'h00, 8'h84, 1'b1, 8'h04);
    dv(8'h00, 8'h80, 1'b1, 8'h80);
    dv(8'h00, 8'hFF, 1'b1, 8'h7F);
    dv(8'h00, 8'h81, 1'b1, 8'h02);
    dv(8'h01, 8'h83, 1'b1, 8'h06);
    dv(8'h02, 8'h83, 1'b1, 8'h00);
    dv(8'h00, 8'h04, 1'b1, 8'h00);
    dv(8'h00, 8'h84, 1'b0, 8'h00);
    dv(8'h04, 8'h84, 1'b0, 8'h04);
    tally_and_finish;
end
endmodule

//--- testbench/apcr_host_model.sv
// Host model: drives serial clocks, data and the secondary pins.
// Assumes one mclk domain; lines change just after each rising edge.
`timescale 1ns/100ps
module apcr_host_model (
    input  wire mclk,
    input  wire srst,
    input  wire hostOwns,   // High while the host owns the bit clock
    output reg  bitClk,
    output reg  frameClk,
    output reg  data,
    output reg  gpioLine,
    output reg  altBit,
    output reg  altFrame,
    output reg  altData
);
reg [4:0] cnt;              // Pattern source, a different pattern per line
// Distinct patterns so a wrong mux choice shows quickly
always @(posedge mclk) begin
    cnt <= srst ? 5'h00 : cnt + 5'h01;
    bitClk <= hostOwns & cnt[0];    // Released line parks low
    frameClk <= cnt[3];
    data <= cnt[1] ^ cnt[4];
    gpioLine <= cnt[2];
    altBit <= cnt[1];
    altFrame <= ~cnt[0];
    altData <= cnt[2] ^ cnt[0];
end
endmodule
